/* shared/nva_pkg.sv */
// constants, encodings and timing for the nonvolatile access block
package nva_pkg;
    localparam int unsigned NVA_CLK_MHZ      = 100;
    localparam int unsigned NVA_WRITE_MS     = 20;
    // longest write time, rounded down to whole cycles
    localparam int unsigned NVA_WRITE_CYC    = NVA_WRITE_MS * 1000
                                               * NVA_CLK_MHZ;
    localparam int unsigned NVA_TMR_W        = 24;
    localparam int unsigned NVA_DW           = 8;
    localparam int unsigned NVA_FL_AW        = 16;
    localparam int unsigned NVA_FL_ROW_BYTES = 256;
    localparam int unsigned NVA_FL_ECC_BYTES = 32;
    localparam int unsigned NVA_FL_ROWS      = 256;
    localparam int unsigned NVA_FL_ROW_LSB   = 8;
    localparam int unsigned NVA_EE_AW        = 11;
    localparam int unsigned NVA_EE_ROWS      = 128;
    localparam int unsigned NVA_EE_ROW_BYTES = 16;
    localparam int unsigned NVA_EE_ROW_LSB   = 4;
    localparam logic [7:0]  NVA_ERASE_VAL    = 8'h00;
    localparam logic [7:0]  NVA_EE_INIT      = 8'h00;
    localparam logic [15:0] NVA_WALK_ONE     = 16'h0000;
    localparam logic [15:0] NVA_WALK_EE      = 16'(NVA_EE_ROW_BYTES - 1);
    localparam logic [15:0] NVA_WALK_CHIP    = 16'hffff;

    typedef enum logic [1:0] {
        NVA_LVL_UNPROT,
        NVA_LVL_FACTORY,
        NVA_LVL_FIELD,
        NVA_LVL_FULL
    } nva_level_type;

    typedef enum logic [1:0] {
        NVA_OP_FL_PROG,
        NVA_OP_EE_ROW,
        NVA_OP_CHIP_ERASE,
        NVA_OP_PROT_SET
    } nva_op_type;

    typedef enum logic {
        NVA_ST_IDLE,
        NVA_ST_RUN
    } nva_state_type;
endpackage : nva_pkg

/* logic/nva_mem.sv */
// byte memory with registered read data
`timescale 1ns/1ns
module nva_mem #(
    parameter int unsigned AW   = 11,
    parameter int unsigned DW   = 8,
    parameter logic [DW-1:0] INIT = '0
) (
    input  wire logic          i_core_clk, // core clock
    input  wire logic          i_we,       // write strobe
    input  wire logic [AW-1:0] i_addr,     // byte address
    input  wire logic [DW-1:0] i_wdata,    // write data
    output logic      [DW-1:0] o_rdata     // read data, one cycle late
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    // as-shipped contents; no error correction stored beside data
    initial
    begin
        for (int i = 0; i < (1 << AW); i++)
        begin
            mem_q[i] = INIT;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_we)
        begin
            mem_q[i_addr] <= i_wdata;
        end
        o_rdata <= mem_q[i_addr];
    end
endmodule : nva_mem

/* logic/nva_prot.sv */
// access decision for one flash row protection level
`timescale 1ns/1ns
module nva_prot (
    input  nva_pkg::nva_level_type i_level,    // row protection level
    input  wire logic              i_is_ext,   // request from ext port
    input  wire logic              i_is_write, // write request
    input  wire logic              i_secure,   // device lock set
    output logic                   o_allow     // access permitted
);
    always_comb
    begin
        if (i_is_ext)
        begin
            o_allow = !i_secure
                && ((i_level == nva_pkg::NVA_LVL_UNPROT)
                || (i_level == nva_pkg::NVA_LVL_FACTORY
                && i_is_write));
        end
        else
        begin
            o_allow = (i_level != nva_pkg::NVA_LVL_FULL)
                || !i_is_write;
        end
    end
endmodule : nva_prot

/* logic/nva_access.sv */
// nonvolatile access control: flash protection, eeprom, program engine
`timescale 1ns/1ns
module nva_access #(
    parameter int unsigned WRITE_CYC = nva_pkg::NVA_WRITE_CYC
) (
    input  wire logic        i_core_clk,  // core clock
    input  wire logic        i_rst_b,     // async reset, active low
    input  wire logic        i_sec_lock,  // pulse: set device lock
    input  wire logic        i_cpu_req,   // cpu read request, level
    input  wire logic        i_cpu_we,    // cpu direct store attempt
    input  wire logic        i_cpu_ee,    // 1 eeprom space, 0 flash
    input  wire logic        i_cpu_fetch, // instruction fetch
    input  wire logic [15:0] i_cpu_addr,  // cpu byte address
    output logic             o_cpu_ack,   // read data valid pulse
    output logic             o_cpu_err,   // refused pulse
    output logic      [7:0]  o_cpu_rdata, // read data
    input  wire logic        i_ext_req,   // ext port read request
    input  wire logic        i_ext_we,    // ext direct store attempt
    input  wire logic [15:0] i_ext_addr,  // ext flash byte address
    output logic             o_ext_ack,   // read data valid pulse
    output logic             o_ext_err,   // refused pulse
    output logic      [7:0]  o_ext_rdata, // read data
    input  wire logic        i_ld_valid,  // eeprom row buffer load
    input  wire logic [3:0]  i_ld_idx,    // byte within row buffer
    input  wire logic [7:0]  i_ld_data,   // byte to load
    input  wire logic        i_cmd_valid, // command strobe
    input  wire logic        i_cmd_ext,   // command from ext port
    input  wire logic [1:0]  i_cmd_op,    // command code
    input  wire logic [15:0] i_cmd_addr,  // flash byte or eeprom row
    input  wire logic [7:0]  i_cmd_data,  // data byte or level
    output logic             o_cmd_busy,  // operation in progress
    output logic             o_cmd_done,  // operation finished pulse
    output logic             o_cmd_err,   // command refused pulse
    output logic             o_secure     // device lock state
);
    localparam int unsigned TW = nva_pkg::NVA_TMR_W;
    localparam logic [TW-1:0] TMR_LAST = TW'(WRITE_CYC - 1);

    typedef struct packed {
        nva_pkg::nva_state_type                   st;
        nva_pkg::nva_op_type                      kind;
        logic                                     walking;
        logic [15:0]                              walk;
        logic [15:0]                              walk_end;
        logic [TW-1:0]                            tmr;
        logic [15:0]                              addr;
        logic [7:0]                               data;
        logic [15:0][7:0]                         ld_buf;
        nva_pkg::nva_level_type [255:0]           prot;
        logic [255:0]                             open;
        logic                                     secure;
        logic                                     done;
        logic                                     cerr;
        logic                                     cpu_p1;
        logic                                     cpu_sel_ee;
        logic                                     cpu_ack;
        logic                                     cpu_err;
        logic [7:0]                               cpu_rdata;
        logic                                     ext_p1;
        logic                                     ext_ack;
        logic                                     ext_err;
        logic [7:0]                               ext_rdata;
    } nva_state_t_type;

    nva_state_t_type s_q;
    nva_state_t_type s_d;

    logic        fl_wr;
    logic        ee_wr;
    logic        fl_busy;
    logic        ee_busy;
    logic [15:0] fl_addr;
    logic [7:0]  fl_wdata;
    logic [10:0] ee_addr;
    logic [7:0]  ee_wdata;
    logic [7:0]  fl_rdata;
    logic [7:0]  ee_rdata;
    logic        cpu_allow;
    logic        ext_allow;
    logic        cmd_allow;
    logic        cpu_free;
    logic        cpu_bad;
    logic        cpu_go;
    logic        ext_free;
    logic        ext_bad;
    logic        ext_go;
    logic        cmd_ok;
    logic        cmd_idle;
    nva_pkg::nva_op_type cmd_op;

    function automatic logic [7:0] row_of(input logic [15:0] a);
        row_of = a[nva_pkg::NVA_FL_ROW_LSB +: 8];
    endfunction : row_of

    assign cmd_op = nva_pkg::nva_op_type'(i_cmd_op);

    nva_prot u_cpu_prot (
        .i_level    (s_q.prot[row_of(i_cpu_addr)]),
        .i_is_ext   (1'b0),
        .i_is_write (i_cpu_we),
        .i_secure   (s_q.secure),
        .o_allow    (cpu_allow)
    );

    nva_prot u_ext_prot (
        .i_level    (s_q.prot[row_of(i_ext_addr)]),
        .i_is_ext   (1'b1),
        .i_is_write (i_ext_we),
        .i_secure   (s_q.secure),
        .o_allow    (ext_allow)
    );

    nva_prot u_cmd_prot (
        .i_level    (s_q.prot[row_of(i_cmd_addr)]),
        .i_is_ext   (i_cmd_ext),
        .i_is_write (1'b1),
        .i_secure   (s_q.secure),
        .o_allow    (cmd_allow)
    );

    nva_mem #(
        .AW   (nva_pkg::NVA_FL_AW),
        .DW   (nva_pkg::NVA_DW),
        .INIT (nva_pkg::NVA_ERASE_VAL)
    ) u_flash (
        .i_core_clk (i_core_clk),
        .i_we       (fl_wr),
        .i_addr     (fl_addr),
        .i_wdata    (fl_wdata),
        .o_rdata    (fl_rdata)
    );

    nva_mem #(
        .AW   (nva_pkg::NVA_EE_AW),
        .DW   (nva_pkg::NVA_DW),
        .INIT (nva_pkg::NVA_EE_INIT)
    ) u_eeprom (
        .i_core_clk (i_core_clk),
        .i_we       (ee_wr),
        .i_addr     (ee_addr),
        .i_wdata    (ee_wdata),
        .o_rdata    (ee_rdata)
    );

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.cerr = 1'b0;
        s_d.cpu_ack = 1'b0;
        s_d.cpu_err = 1'b0;
        s_d.ext_ack = 1'b0;
        s_d.ext_err = 1'b0;
        fl_busy = (s_q.st == nva_pkg::NVA_ST_RUN)
            && (s_q.kind != nva_pkg::NVA_OP_EE_ROW);
        ee_busy = (s_q.st == nva_pkg::NVA_ST_RUN)
            && (s_q.kind == nva_pkg::NVA_OP_EE_ROW);
        fl_wr = fl_busy && s_q.walking
            && (s_q.kind != nva_pkg::NVA_OP_PROT_SET);
        ee_wr = ee_busy && s_q.walking;
        fl_wdata = (s_q.kind == nva_pkg::NVA_OP_CHIP_ERASE)
            ? nva_pkg::NVA_ERASE_VAL : s_q.data;
        ee_addr = {s_q.addr[10:4], s_q.walk[3:0]};
        ee_wdata = s_q.ld_buf[s_q.walk[3:0]];

        // direct stores are refused: nonvolatile data change by command
        cpu_free = !s_q.cpu_p1 && !s_q.cpu_ack && !s_q.cpu_err;
        cpu_bad = i_cpu_we
            || (i_cpu_ee && i_cpu_fetch)
            || (!i_cpu_ee && !cpu_allow);
        // flash reads stall during flash program, chip erase and level set, not eeprom writes
        cpu_go = i_cpu_req && cpu_free
            && (cpu_bad || (i_cpu_ee ? !ee_busy : !fl_busy));
        ext_free = !s_q.ext_p1 && !s_q.ext_ack && !s_q.ext_err;
        ext_bad = i_ext_we || !ext_allow;
        ext_go = i_ext_req && ext_free
            && (ext_bad || (!fl_busy && !(cpu_go && !cpu_bad && !i_cpu_ee)));
        if (fl_wr)
        begin
            fl_addr = (s_q.kind == nva_pkg::NVA_OP_CHIP_ERASE)
                ? s_q.walk : s_q.addr;
        end
        else if (cpu_go && !i_cpu_ee)
        begin
            fl_addr = i_cpu_addr;
        end
        else
        begin
            fl_addr = i_ext_addr;
        end
        if (!ee_wr)
        begin
            ee_addr = i_cpu_addr[10:0];
        end

        s_d.cpu_p1 = cpu_go && !cpu_bad;
        if (cpu_go && cpu_bad)
        begin
            s_d.cpu_err = 1'b1;
            s_d.cpu_rdata = 8'h00;
        end
        if (cpu_go)
        begin
            s_d.cpu_sel_ee = i_cpu_ee;
        end
        if (s_q.cpu_p1)
        begin
            s_d.cpu_ack = 1'b1;
            s_d.cpu_rdata = s_q.cpu_sel_ee ? ee_rdata : fl_rdata;
        end
        s_d.ext_p1 = ext_go && !ext_bad;
        if (ext_go && ext_bad)
        begin
            s_d.ext_err = 1'b1;
            s_d.ext_rdata = 8'h00;
        end
        if (s_q.ext_p1)
        begin
            s_d.ext_ack = 1'b1;
            s_d.ext_rdata = fl_rdata;
        end

        if (i_sec_lock)
        begin
            s_d.secure = 1'b1;
        end
        if (i_ld_valid && !ee_busy)
        begin
            s_d.ld_buf[i_ld_idx] = i_ld_data;
        end

        cmd_idle = (s_q.st == nva_pkg::NVA_ST_IDLE);
        unique case (cmd_op)
            nva_pkg::NVA_OP_FL_PROG:    cmd_ok = cmd_allow;
            nva_pkg::NVA_OP_EE_ROW:     cmd_ok = !(i_cmd_ext && s_q.secure);
            nva_pkg::NVA_OP_CHIP_ERASE: cmd_ok = !(i_cmd_ext && s_q.secure);
            nva_pkg::NVA_OP_PROT_SET:   cmd_ok = !(i_cmd_ext && s_q.secure)
                && s_q.open[row_of(i_cmd_addr)];
        endcase

        unique case (s_q.st)
            nva_pkg::NVA_ST_IDLE:
            begin
                if (i_cmd_valid && cmd_ok)
                begin
                    s_d.st = nva_pkg::NVA_ST_RUN;
                    s_d.kind = cmd_op;
                    s_d.addr = i_cmd_addr;
                    s_d.data = i_cmd_data;
                    s_d.walk = 16'h0000;
                    s_d.walking = 1'b1;
                    s_d.tmr = '0;
                    unique case (cmd_op)
                        nva_pkg::NVA_OP_EE_ROW:
                            s_d.walk_end = nva_pkg::NVA_WALK_EE;
                        nva_pkg::NVA_OP_CHIP_ERASE:
                            s_d.walk_end = nva_pkg::NVA_WALK_CHIP;
                        nva_pkg::NVA_OP_FL_PROG,
                        nva_pkg::NVA_OP_PROT_SET:
                            s_d.walk_end = nva_pkg::NVA_WALK_ONE;
                    endcase
                    if (cmd_op == nva_pkg::NVA_OP_PROT_SET)
                    begin
                        s_d.prot[row_of(i_cmd_addr)] =
                            nva_pkg::nva_level_type'(i_cmd_data[1:0]);
                        s_d.open[row_of(i_cmd_addr)] = 1'b0;
                    end
                end
                else if (i_cmd_valid)
                begin
                    s_d.cerr = 1'b1;
                end
            end
            nva_pkg::NVA_ST_RUN:
            begin
                if (i_cmd_valid)
                begin
                    s_d.cerr = 1'b1;
                end
                if (s_q.walking)
                begin
                    s_d.walking = (s_q.walk != s_q.walk_end);
                    s_d.walk = s_q.walk + 16'h0001;
                end
                if (s_q.tmr != TMR_LAST)
                begin
                    s_d.tmr = s_q.tmr + TW'(1);
                end
                // a write holds busy for the full nonvolatile write time
                if (!s_q.walking && (s_q.tmr == TMR_LAST))
                begin
                    s_d.st = nva_pkg::NVA_ST_IDLE;
                    s_d.done = 1'b1;
                    if (s_q.kind == nva_pkg::NVA_OP_CHIP_ERASE)
                    begin
                        s_d.prot = '0;
                        s_d.open = '1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_cmd_busy  = (s_q.st == nva_pkg::NVA_ST_RUN);
    assign o_cmd_done  = s_q.done;
    assign o_cmd_err   = s_q.cerr;
    assign o_cpu_ack   = s_q.cpu_ack;
    assign o_cpu_err   = s_q.cpu_err;
    assign o_cpu_rdata = s_q.cpu_rdata;
    assign o_ext_ack   = s_q.ext_ack;
    assign o_ext_err   = s_q.ext_err;
    assign o_ext_rdata = s_q.ext_rdata;
    assign o_secure    = s_q.secure;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence good_read_s;
        !o_cpu_ack ##1 o_cpu_ack && !o_cpu_err;
    endsequence
    sequence ext_read_s;
        !o_ext_err ##1 o_ext_ack;
    endsequence

    a_busy_refuse: assert property (o_cmd_busy && i_cmd_valid |=>
        o_cmd_err && !o_cmd_done)
        else $error("command taken while busy");
    a_store_refused: assert property (cpu_go && i_cpu_we |=>
        o_cpu_err && !o_cpu_ack)
        else $error("direct store not refused");
    a_fetch_eeprom: assert property (cpu_go && i_cpu_ee && i_cpu_fetch
        |=> o_cpu_err)
        else $error("fetch from eeprom not refused");
    a_ee_read_lat: assert property (cpu_go && !cpu_bad && i_cpu_ee
        |=> good_read_s)
        else $error("eeprom read latency wrong");
    a_fetch_during_ee: assert property (ee_busy && i_cpu_req
        && cpu_free && !i_cpu_ee && !cpu_bad |=> good_read_s)
        else $error("flash read stalled by eeprom write");
    a_flash_suspend: assert property (fl_busy && i_cpu_req
        && !i_cpu_ee && !cpu_bad |-> ##2 !o_cpu_ack)
        else $error("flash read during programming");
    a_full_no_write: assert property (i_cmd_valid && cmd_idle
        && cmd_op == nva_pkg::NVA_OP_FL_PROG && !i_cmd_ext
        && s_q.prot[row_of(i_cmd_addr)] == nva_pkg::NVA_LVL_FULL
        |=> o_cmd_err && !o_cmd_busy)
        else $error("write into fully protected row");
    a_factory_read: assert property (ext_go
        && s_q.prot[row_of(i_ext_addr)] == nva_pkg::NVA_LVL_FACTORY
        |=> o_ext_err ##1 !o_ext_ack)
        else $error("external read of factory row");
    a_unprot_read: assert property (ext_go && !i_ext_we && !s_q.secure
        && s_q.prot[row_of(i_ext_addr)] == nva_pkg::NVA_LVL_UNPROT
        |=> ext_read_s)
        else $error("external read of open row failed");
    a_secure_ext: assert property (s_q.secure && ext_go |=>
        o_ext_err && o_ext_rdata == 8'h00)
        else $error("external access after lock");
    a_level_locked: assert property (i_cmd_valid && cmd_idle
        && cmd_op == nva_pkg::NVA_OP_PROT_SET
        && !s_q.open[row_of(i_cmd_addr)]
        |=> o_cmd_err && $stable(s_q.prot))
        else $error("level changed without erase");
endmodule : nva_access

/* dv/nva_host.sv */
// partner model: one requester on a read port, cpu or external tool
`timescale 1ns/1ns
module nva_host (
    input  wire logic        i_clk,   // core clock
    input  wire logic        i_rst_b, // reset, active low
    input  wire logic        i_go,    // start one request
    input  wire logic        i_we,    // store attempt
    input  wire logic [15:0] i_addr,  // byte address
    input  wire logic        i_ack,   // answer with data
    input  wire logic        i_err,   // answer refused
    input  wire logic [7:0]  i_rdata, // read data
    output logic             o_req,   // request level
    output logic             o_we,    // store qualifier
    output logic      [15:0] o_addr,  // held address
    output logic             o_done,  // answer taken pulse
    output logic             o_err,   // last answer refused
    output logic      [7:0]  o_data   // last data taken
);
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_req  <= 1'b0;
            o_we   <= 1'b0;
            o_addr <= 16'h0000;
            o_done <= 1'b0;
            o_err  <= 1'b0;
            o_data <= 8'h00;
        end
        else
        begin
            o_done <= 1'b0;
            if (o_req && (i_ack || i_err))
            begin
                // released address flips so stale values never match
                o_req  <= 1'b0;
                o_we   <= 1'b0;
                o_addr <= ~o_addr;
                o_done <= 1'b1;
                o_err  <= i_err;
                o_data <= i_rdata;
            end
            else if (i_go && !o_req)
            begin
                o_req  <= 1'b1;
                o_we   <= i_we;
                o_addr <= i_addr;
            end
        end
    end
endmodule : nva_host

/* dv/test_nva_access.sv */
// self-checking testbench for the nonvolatile access block
`timescale 1ns/1ns
module test_nva_access;
    logic        clk, rst_b, lock, c_go, c_we, c_ee, c_fe, e_go, e_we;
    logic        ld_v, cmd_v, cmd_ext, d_seen, e_seen, busy, done;
    logic        cerr, secure, c_req, c_rwe, c_ack, c_er, c_dn, c_bad;
    logic        e_req, e_rwe, e_ack, e_er, e_dn, e_bad;
    logic [15:0] c_a, e_a, cmd_a, c_ra, e_ra;
    logic [7:0]  ld_d, cmd_d, c_rd, e_rd, c_dat, e_dat, l;
    logic [3:0]  ld_i;
    logic [1:0]  cmd_op;
    int          num_errors, check_count, i;

    nva_host u_cpu_host (.i_clk(clk), .i_rst_b(rst_b), .i_go(c_go),
        .i_we(c_we), .i_addr(c_a), .i_ack(c_ack), .i_err(c_er),
        .i_rdata(c_rd), .o_req(c_req), .o_we(c_rwe), .o_addr(c_ra),
        .o_done(c_dn), .o_err(c_bad), .o_data(c_dat));
    nva_host u_ext_host (.i_clk(clk), .i_rst_b(rst_b), .i_go(e_go),
        .i_we(e_we), .i_addr(e_a), .i_ack(e_ack), .i_err(e_er),
        .i_rdata(e_rd), .o_req(e_req), .o_we(e_rwe), .o_addr(e_ra),
        .o_done(e_dn), .o_err(e_bad), .o_data(e_dat));
    nva_access #(.WRITE_CYC(20)) u_nva_access (.i_core_clk(clk),
        .i_rst_b(rst_b), .i_sec_lock(lock), .i_cpu_req(c_req),
        .i_cpu_we(c_rwe), .i_cpu_ee(c_ee), .i_cpu_fetch(c_fe),
        .i_cpu_addr(c_ra), .o_cpu_ack(c_ack), .o_cpu_err(c_er),
        .o_cpu_rdata(c_rd), .i_ext_req(e_req), .i_ext_we(e_rwe),
        .i_ext_addr(e_ra), .o_ext_ack(e_ack), .o_ext_err(e_er),
        .o_ext_rdata(e_rd), .i_ld_valid(ld_v), .i_ld_idx(ld_i),
        .i_ld_data(ld_d), .i_cmd_valid(cmd_v), .i_cmd_ext(cmd_ext),
        .i_cmd_op(cmd_op), .i_cmd_addr(cmd_a), .i_cmd_data(cmd_d),
        .o_cmd_busy(busy), .o_cmd_done(done), .o_cmd_err(cerr),
        .o_secure(secure));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // pulses last one cycle, so latch them for the waiting tasks
    always @(negedge clk)
    begin
        if (done) d_seen = 1'b1;
        if (cerr) e_seen = 1'b1;
    end

    task end_sim;
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task acc(input logic ext, ee, fe, we, input logic [15:0] a,
             input logic x_err, input logic [7:0] x_d);
        @(negedge clk);
        c_ee = ee;
        c_fe = fe;
        if (ext) begin e_a = a; e_we = we; e_go = 1'b1; end
        else begin c_a = a; c_we = we; c_go = 1'b1; end
        @(negedge clk);
        c_go = 1'b0;
        e_go = 1'b0;
        for (i = 0; i < 200 && !(ext ? e_dn : c_dn); i++) @(negedge clk);
        if (i == 200)
        begin
            chk({7'h0, ext ? e_dn : c_dn}, 8'h01);
            end_sim;
        end
        chk({7'h0, ext ? e_bad : c_bad}, {7'h0, x_err});
        chk(ext ? e_dat : c_dat, x_d);
    endtask : acc

    task cmd(input logic ext, input logic [1:0] op,
             input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        cmd_ext = ext;
        cmd_op = op;
        cmd_a = a;
        cmd_d = d;
        cmd_v = 1'b1;
        @(negedge clk);
        cmd_v = 1'b0;
    endtask : cmd

    task cwait(input logic x_err);
        for (i = 0; i < 70000 && !(d_seen || e_seen); i++) @(negedge clk);
        if (i == 70000)
        begin
            chk({7'h0, d_seen || e_seen}, 8'h01);
            end_sim;
        end
        chk({7'h0, e_seen}, {7'h0, x_err});
        d_seen = 1'b0;
        e_seen = 1'b0;
    endtask : cwait

    task t_reset;
        chk({6'h0, busy, secure}, 8'h00);
        acc(0, 1, 0, 0, 16'h07ff, 0, 8'h00);
    endtask : t_reset

    task t_eeprom;
        @(negedge clk);
        ld_v = 1'b1;
        for (i = 0; i < 16; i++)
        begin
            ld_i = 4'(i);
            ld_d = 8'ha0 + 8'(i);
            @(negedge clk);
        end
        ld_v = 1'b0;
        cmd(0, 2'h1, 16'h0050, 8'h00);
        acc(0, 0, 0, 0, 16'h0000, 0, 8'h00);
        chk({7'h0, busy}, 8'h01);
        cmd(0, 2'h1, 16'h0060, 8'h00);
        cwait(1);
        cwait(0);
        acc(0, 1, 0, 0, 16'h0050, 0, 8'ha0);
        acc(0, 1, 0, 0, 16'h005f, 0, 8'haf);
        acc(0, 1, 0, 0, 16'h0060, 0, 8'h00);
        acc(0, 1, 0, 1, 16'h0050, 1, 8'h00);
        acc(0, 1, 1, 0, 16'h0051, 1, 8'h00);
        acc(0, 1, 0, 0, 16'h0050, 0, 8'ha0);
    endtask : t_eeprom

    task t_prot;
        cmd(0, 2'h2, 16'h0000, 8'h00);
        cwait(0);
        for (l = 0; l < 4; l++)
        begin
            cmd(0, 2'h3, {l, 8'h00}, l);
            cwait(0);
        end
        cmd(0, 2'h3, 16'h0100, 8'h00);
        cwait(1);
        for (l = 0; l < 4; l++)
        begin
            cmd(1, 2'h0, {l, 8'hff}, 8'h50 + l);
            cwait(l > 1);
            cmd(0, 2'h0, {l, 8'hfe}, 8'h60 + l);
            cwait(l == 3);
            acc(1, 0, 0, 0, {l, 8'hff}, l != 0,
                (l == 0) ? 8'h50 : 8'h00);
            acc(0, 0, 0, 0, {l, 8'hff}, 0,
                (l < 2) ? 8'h50 + l : 8'h00);
            acc(0, 0, 0, 0, {l, 8'hfe}, 0,
                (l < 3) ? 8'h60 + l : 8'h00);
        end
        cmd(0, 2'h0, 16'h0010, 8'h77);
        acc(0, 0, 0, 0, 16'h0010, 0, 8'h77);
        chk({7'h0, busy}, 8'h00);
        cwait(0);
    endtask : t_prot

    task t_lock;
        @(negedge clk);
        lock = 1'b1;
        @(negedge clk);
        lock = 1'b0;
        @(negedge clk);
        chk({7'h0, secure}, 8'h01);
        acc(1, 0, 0, 0, 16'h00ff, 1, 8'h00);
        acc(1, 0, 0, 1, 16'h00ff, 1, 8'h00);
        cmd(1, 2'h1, 16'h0050, 8'h00);
        cwait(1);
        acc(0, 0, 0, 0, 16'h00ff, 0, 8'h50);
        // reset only while idle, so no write is cut short
        chk({7'h0, busy}, 8'h00);
        rst_b = 1'b0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        chk({7'h0, secure}, 8'h00);
        acc(0, 1, 0, 0, 16'h0050, 0, 8'ha0);
    endtask : t_lock

    initial
    begin
        {rst_b, lock, c_go, c_we, c_ee, c_fe, e_go, e_we} = '0;
        {ld_v, cmd_v, cmd_ext, d_seen, e_seen, cmd_op, ld_i} = '0;
        {c_a, e_a, cmd_a, ld_d, cmd_d} = '0;
        num_errors = 0;
        check_count = 0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_reset;
        t_eeprom;
        t_prot;
        t_lock;
        end_sim;
    end
endmodule : test_nva_access
